// ===== hdl/crc16_pkg.sv
// package: register map, reset values and polynomials for the crc16 byte engine
package crc16_pkg;
	// byte addresses of the four registers on apb
	localparam logic [7:0] ADDR_BYTE_INPUT    = 8'h00;
	localparam logic [7:0] ADDR_CHECKSUM_LOW  = 8'h04;
	localparam logic [7:0] ADDR_CHECKSUM_HIGH = 8'h08;
	localparam logic [7:0] ADDR_CONTROL       = 8'h0c;
	// reset values
	localparam logic [7:0]  RST_BYTE_INPUT = 8'h00;
	localparam logic [15:0] RST_CHECKSUM   = 16'h0000;
	localparam logic        RST_POLYNOMIAL_SELECT_SEL   = 1'b0;
	// field position of polynomial_select in crc_control
	localparam int          POLYNOMIAL_SELECT_SEL_BIT   = 0;
	// feedback constants
	localparam logic [15:0] POLYNOMIAL_SELECT_CCITT     = 16'h1021;
	localparam logic [15:0] POLYNOMIAL_SELECT_CRC16     = 16'h8005;
	localparam int          BITS_PER_BYTE  = 8;
endpackage

// ===== hdl/crc16_byte_engine.sv
// apb-attached byte-serial 16-bit crc engine with two selectable polynomials
`timescale 1ns/1ps
`default_nettype none
module crc16_byte_engine
	import crc16_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr
);

	// one byte step of the crc, fully unrolled combinationally
	function automatic logic [15:0] crc_byte(input logic [15:0] sum, input logic [7:0] din, input logic sel);
		logic [15:0] t;
		logic [15:0] polynomial_select;
		t    = sum ^ {din, 8'h00};
		polynomial_select = sel ? POLYNOMIAL_SELECT_CRC16 : POLYNOMIAL_SELECT_CCITT;
		for (int i = 0; i < BITS_PER_BYTE; i++) begin
			t = t[15] ? ({t[14:0], 1'b0} ^ polynomial_select) : {t[14:0], 1'b0};
		end
		return t;
	endfunction

	logic [7:0]  byte_input_q;
	logic [15:0] running_checksum_q;
	logic        polynomial_select_q;
	logic [15:0] checksum_d;

	// access phase decode; the slave answers in the second access cycle
	wire         access     = psel & penable;
	wire         wr_acc     = access & pwrite;
	wire         rd_acc     = access & ~pwrite;
	wire  [7:0]  word_addr  = paddr[7:0];
	wire         hit_input  = (paddr[31:8] == 24'h000000) && (word_addr == ADDR_BYTE_INPUT);
	wire         hit_low    = (paddr[31:8] == 24'h000000) && (word_addr == ADDR_CHECKSUM_LOW);
	wire         hit_high   = (paddr[31:8] == 24'h000000) && (word_addr == ADDR_CHECKSUM_HIGH);
	wire         hit_ctrl   = (paddr[31:8] == 24'h000000) && (word_addr == ADDR_CONTROL);
	wire         mapped     = hit_input | hit_low | hit_high | hit_ctrl;
	// only byte lane 0 carries data; a write without it changes nothing
	wire         lane0      = pstrb[0];
	wire         wr_input   = wr_acc & hit_input & lane0 & ~pready;
	wire         wr_low     = wr_acc & hit_low & lane0 & ~pready;
	wire         wr_high    = wr_acc & hit_high & lane0 & ~pready;
	wire         wr_ctrl    = wr_acc & hit_ctrl & lane0 & ~pready;
	wire  [15:0] next_sum   = crc_byte(running_checksum_q, pwdata[7:0], polynomial_select_q);

	// checksum next value: crc update wins the pair, direct loads fill one byte
	always_comb begin
		checksum_d = running_checksum_q;
		if (wr_input) begin
			checksum_d = next_sum;
		end else begin
			if (wr_low) begin
				checksum_d[7:0] = pwdata[7:0];
			end
			if (wr_high) begin
				checksum_d[15:8] = pwdata[7:0];
			end
		end
	end

	// register file
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_input_q        <= RST_BYTE_INPUT;
			running_checksum_q  <= RST_CHECKSUM;
			polynomial_select_q <= RST_POLYNOMIAL_SELECT_SEL;
		end else begin
			if (wr_input) begin
				byte_input_q <= pwdata[7:0];
			end
			if (wr_ctrl) begin
				polynomial_select_q <= pwdata[POLYNOMIAL_SELECT_SEL_BIT];
			end
			running_checksum_q <= checksum_d;
		end
	end

	// read mux; upper bits zero, unused control bits zero
	wire [31:0] rd_mux = hit_input ? {24'h000000, byte_input_q} :
	                     hit_low   ? {24'h000000, running_checksum_q[7:0]} :
	                     hit_high  ? {24'h000000, running_checksum_q[15:8]} :
	                     hit_ctrl  ? {31'h00000000, polynomial_select_q} :
	                     32'h00000000;

	// bus answer: pready pulses one cycle after the access phase begins,
	// so every transfer has exactly one wait state and outputs stay registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= access & ~pready;
			pslverr <= access & ~pready & ~mapped;
			prdata  <= (rd_acc & ~pready) ? rd_mux : 32'h00000000;
		end
	end

	// checks
	property p_update;
		@(posedge pclk) disable iff (!presetn)
		wr_input |=> running_checksum_q == crc_byte($past(running_checksum_q), $past(pwdata[7:0]), $past(polynomial_select_q));
	endproperty
	a_update: assert property (p_update) else $error("checksum not updated from input byte");

	property p_ccitt_one;
		@(posedge pclk) disable iff (!presetn)
		(wr_input && running_checksum_q == 16'h0000 && pwdata[7:0] == 8'h01 && !polynomial_select_q)
		|=> running_checksum_q == 16'h1021;
	endproperty
	a_ccitt_one: assert property (p_ccitt_one) else $error("ccitt single byte wrong");

	property p_crc16_three;
		@(posedge pclk) disable iff (!presetn)
		(wr_input && running_checksum_q == 16'h0000 && pwdata[7:0] == 8'h03 && polynomial_select_q)
		|=> running_checksum_q == 16'h000a;
	endproperty
	a_crc16_three: assert property (p_crc16_three) else $error("crc16 single byte wrong");

	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		!(wr_input | wr_low | wr_high) |=> $stable(running_checksum_q);
	endproperty
	a_hold: assert property (p_hold) else $error("checksum changed without a write");

	property p_input_read;
		@(posedge pclk) disable iff (!presetn)
		(rd_acc && hit_input && !pready) |=> prdata[7:0] == byte_input_q && $stable(running_checksum_q);
	endproperty
	a_input_read: assert property (p_input_read) else $error("input read wrong or started update");

	property p_ctrl_read;
		@(posedge pclk) disable iff (!presetn)
		(rd_acc && hit_ctrl && !pready) |=> prdata[31:1] == 31'h00000000 && prdata[0] == polynomial_select_q;
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");

	property p_low_load;
		@(posedge pclk) disable iff (!presetn)
		wr_low && !wr_high |=> running_checksum_q == {$past(running_checksum_q[15:8]), $past(pwdata[7:0])};
	endproperty
	a_low_load: assert property (p_low_load) else $error("low byte load wrong");

	property p_polynomial_select_sel;
		@(posedge pclk) disable iff (!presetn)
		wr_ctrl |=> polynomial_select_q == $past(pwdata[0]);
	endproperty
	a_polynomial_select_sel: assert property (p_polynomial_select_sel) else $error("polynomial select not written");

	property p_ready_one;
		@(posedge pclk) disable iff (!presetn)
		(access && !pready) |=> pready ##1 !pready;
	endproperty
	a_ready_one: assert property (p_ready_one) else $error("pready not a single pulse");

	property p_input_store;
		@(posedge pclk) disable iff (!presetn)
		wr_input |=> byte_input_q == $past(pwdata[7:0]);
	endproperty
	a_input_store: assert property (p_input_store) else $error("input byte not stored");

	// bus answer shape: one pulse, error only with it, data only while it stands
	property p_ready_idle;
		@(posedge pclk) disable iff (!presetn)
		!access |=> !pready;
	endproperty
	a_ready_idle: assert property (p_ready_idle) else $error("pready without an access");

	property p_setup_quiet;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |-> !pready;
	endproperty
	a_setup_quiet: assert property (p_setup_quiet) else $error("pready during setup");

	property p_err_with_ready;
		@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");

	property p_err_unmapped;
		@(posedge pclk) disable iff (!presetn)
		(access && !pready && !mapped) |=> pslverr;
	endproperty
	a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");

	property p_no_err_mapped;
		@(posedge pclk) disable iff (!presetn)
		(access && !pready && mapped) |=> !pslverr;
	endproperty
	a_no_err_mapped: assert property (p_no_err_mapped) else $error("mapped access refused");

	property p_rdata_idle;
		@(posedge pclk) disable iff (!presetn)
		!pready |-> prdata == 32'h00000000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");

	property p_rdata_upper;
		@(posedge pclk) disable iff (!presetn)
		prdata[31:8] == 24'h000000;
	endproperty
	a_rdata_upper: assert property (p_rdata_upper) else $error("read data upper bits set");

	// write answers carry no data, so a stale read can never leak out
	property p_rdata_write;
		@(posedge pclk) disable iff (!presetn)
		(access && pwrite && !pready) |=> prdata == 32'h00000000;
	endproperty
	a_rdata_write: assert property (p_rdata_write) else $error("read data on a write");

	// checksum readback of both halves, then the high byte load
	property p_low_read;
		@(posedge pclk) disable iff (!presetn)
		(rd_acc && hit_low && !pready) |=> prdata[7:0] == running_checksum_q[7:0];
	endproperty
	a_low_read: assert property (p_low_read) else $error("low byte readback wrong");

	property p_high_read;
		@(posedge pclk) disable iff (!presetn)
		(rd_acc && hit_high && !pready) |=> prdata[7:0] == running_checksum_q[15:8];
	endproperty
	a_high_read: assert property (p_high_read) else $error("high byte readback wrong");

	property p_high_load;
		@(posedge pclk) disable iff (!presetn)
		wr_high && !wr_low |=> running_checksum_q == {$past(pwdata[7:0]), $past(running_checksum_q[7:0])};
	endproperty
	a_high_load: assert property (p_high_load) else $error("high byte load wrong");

	// state that only its own write may move
	property p_input_hold;
		@(posedge pclk) disable iff (!presetn)
		!wr_input |=> $stable(byte_input_q);
	endproperty
	a_input_hold: assert property (p_input_hold) else $error("input byte changed without a write");

	property p_polynomial_select_hold;
		@(posedge pclk) disable iff (!presetn)
		!wr_ctrl |=> $stable(polynomial_select_q);
	endproperty
	a_polynomial_select_hold: assert property (p_polynomial_select_hold) else $error("select changed without a write");

	property p_read_no_change;
		@(posedge pclk) disable iff (!presetn)
		rd_acc |=> $stable(running_checksum_q);
	endproperty
	a_read_no_change: assert property (p_read_no_change) else $error("read moved the checksum");

	property p_no_strobe;
		@(posedge pclk) disable iff (!presetn)
		(access && pwrite && !pstrb[0]) |=> $stable(running_checksum_q) && $stable(byte_input_q);
	endproperty
	a_no_strobe: assert property (p_no_strobe) else $error("strobe-less write had an effect");

	// single-byte results of both polynomials from a cleared pair
	property p_ccitt_zero;
		@(posedge pclk) disable iff (!presetn)
		(wr_input && running_checksum_q == 16'h0000 && pwdata[7:0] == 8'h00) |=> running_checksum_q == 16'h0000;
	endproperty
	a_ccitt_zero: assert property (p_ccitt_zero) else $error("zero byte from zero not zero");

	property p_ccitt_two;
		@(posedge pclk) disable iff (!presetn)
		(wr_input && running_checksum_q == 16'h0000 && pwdata[7:0] == 8'h02 && !polynomial_select_q)
		|=> running_checksum_q == 16'h2042;
	endproperty
	a_ccitt_two: assert property (p_ccitt_two) else $error("ccitt byte two wrong");

	property p_ccitt_seven;
		@(posedge pclk) disable iff (!presetn)
		(wr_input && running_checksum_q == 16'h0000 && pwdata[7:0] == 8'h07 && !polynomial_select_q)
		|=> running_checksum_q == 16'h70e7;
	endproperty
	a_ccitt_seven: assert property (p_ccitt_seven) else $error("ccitt byte seven wrong");

	property p_crc16_one;
		@(posedge pclk) disable iff (!presetn)
		(wr_input && running_checksum_q == 16'h0000 && pwdata[7:0] == 8'h01 && polynomial_select_q)
		|=> running_checksum_q == 16'h8005;
	endproperty
	a_crc16_one: assert property (p_crc16_one) else $error("crc16 byte one wrong");

	property p_crc16_seven;
		@(posedge pclk) disable iff (!presetn)
		(wr_input && running_checksum_q == 16'h0000 && pwdata[7:0] == 8'h07 && polynomial_select_q)
		|=> running_checksum_q == 16'h8011;
	endproperty
	a_crc16_seven: assert property (p_crc16_seven) else $error("crc16 byte seven wrong");

endmodule
`default_nettype wire

// ===== tb/tb.sv
// testbench: apb register, polynomial and checksum checks for the crc16 byte engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin miscompares++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb;
	import crc16_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hf;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	int          miscompares = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	logic [31:0] r;
	logic        e;
	logic [15:0] v;
	// single-byte results for inputs 00..07 from zero, ccitt row then crc16 row
	logic [15:0] one_t [2][8] = '{'{16'h0000, 16'h1021, 16'h2042, 16'h3063, 16'h4084, 16'h50a5, 16'h60c6, 16'h70e7},
		'{16'h0000, 16'h8005, 16'h800f, 16'h000a, 16'h801b, 16'h001e, 16'h0014, 16'h8011}};
	logic [15:0] chn_t [2][4] = '{'{16'hff9f, 16'hbbc3, 16'ha367, 16'hd0fa}, '{16'h0110, 16'h91f1, 16'hf2de, 16'h5c43}};
	logic [7:0]  chn_b [4] = '{8'h78, 8'h56, 8'h34, 8'h12};
	crc16_byte_engine dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	always #2 pclk = ~pclk;
	// hang guard: far above the 151 transfers of the run
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			give_verdict();
		end
	end
	task automatic give_verdict;
		if (miscompares == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// one apb transfer; an idle edge first so psel is never assigned twice in a step
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= {24'h0, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d, 4'hf);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 8'h00, 4'h0);
	endtask
	task automatic rd16;
		rd(ADDR_CHECKSUM_HIGH);
		v[15:8] = r[7:0];
		rd(ADDR_CHECKSUM_LOW);
		v[7:0] = r[7:0];
	endtask
	task automatic clr;
		wr(ADDR_CHECKSUM_LOW, 8'h00);
		wr(ADDR_CHECKSUM_HIGH, 8'h00);
	endtask
	task automatic crc_f(input logic [15:0] c, input logic [7:0] b, input logic p, output logic [15:0] t);
		t = c ^ {b, 8'h00};
		for (int i = 0; i < 8; i++) t = t[15] ? ((t << 1) ^ (p ? POLYNOMIAL_SELECT_CRC16 : POLYNOMIAL_SELECT_CCITT)) : (t << 1);
	endtask
	// reset values of all four registers, then an unmapped address
	task automatic t_reset;
		for (int a = 0; a < 16; a += 4) begin
			rd(a[7:0]);
			`CHK("reset value", 32'h0, r)
		end
		rd(8'h10);
		`CHK("unmapped err", 1'b1, e)
		`CHK("unmapped data", 32'h0, r)
	endtask
	// control: only the select bit holds
	task automatic t_ctrl;
		wr(ADDR_CONTROL, 8'hff);
		rd(ADDR_CONTROL);
		`CHK("control", 32'h1, r)
		wr(ADDR_CONTROL, 8'h00);
	endtask
	// every single byte 00..07 under both polynomials
	task automatic t_single;
		for (int p = 0; p < 2; p++) for (int b = 0; b < 8; b++) begin
			clr();
			wr(ADDR_CONTROL, {7'h0, p[0]});
			wr(ADDR_BYTE_INPUT, b[7:0]);
			rd16();
			`CHK("single", one_t[p][b], v)
		end
	endtask
	// four chained bytes, program words written low byte then high byte
	task automatic t_chain;
		for (int p = 0; p < 2; p++) begin
			clr();
			wr(ADDR_CONTROL, {7'h0, p[0]});
			for (int i = 0; i < 4; i++) begin
				wr(ADDR_BYTE_INPUT, chn_b[i]);
				rd16();
				`CHK("chain", chn_t[p][i], v)
			end
			rd(ADDR_BYTE_INPUT);
			`CHK("input readback", 32'h12, r)
			rd16();
			`CHK("read no update", chn_t[p][3], v)
		end
	endtask
	// direct load, strobe-less write ignored, then chaining from the loaded seed
	task automatic t_load;
		logic [15:0] x;
		wr(ADDR_CHECKSUM_LOW, 8'h34);
		wr(ADDR_CHECKSUM_HIGH, 8'h12);
		rd16();
		`CHK("direct load", 16'h1234, v)
		apb(1'b1, ADDR_BYTE_INPUT, 8'h01, 4'h0);
		rd16();
		`CHK("no strobe", 16'h1234, v)
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_BYTE_INPUT, 8'h01);
		crc_f(16'h1234, 8'h01, 1'b0, x);
		rd16();
		`CHK("seeded", x, v)
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_ctrl();
		t_single();
		t_chain();
		t_load();
		give_verdict();
	end
endmodule
`default_nettype wire
